// *** hdl/adc_mode_ctrl.sv ***
// converter mode control top: AHB-Lite registers, sequencer and calibration path
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "adc_mode_consts.svh"

module adc_mode_ctrl #(
    parameter int DATA_W = 24,
    parameter int FILTER_LATENCY = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    output logic modulator_run,
    output logic clock_source_select,
    output logic conversion_abort,
    output logic result_valid
);
    logic [23:0] ctrl_one_reg, ctrl_one_next;
    logic [23:0] ctrl_two_reg, ctrl_two_next;
    logic [DATA_W-1:0] gain_reg, gain_next;
    logic [DATA_W-1:0] offset_reg, offset_next;
    logic [DATA_W-1:0] result_reg, result_next;
    logic ready_reg, ready_next;
    logic result_valid_reg, result_valid_next;
    logic wr_pend_reg, wr_pend_next;
    logic [9:0] wr_idx_reg, wr_idx_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic addr_take;
    logic rd_take;
    logic start;
    logic take;
    logic running;
    logic [1:0] pd_status;
    logic [DATA_W-1:0] corrected;
    logic change_one;
    logic change_two;
    adc_mode_pkg::mode_cfg_t cfg;

    // merge writable bits of a write into a register, keeping read-only bits
    function automatic logic [23:0] merge(input logic [23:0] old_v, input logic [31:0] wd,
                                          input logic [23:0] mask);
        merge = (old_v & ~mask) | (wd[23:0] & mask);
    endfunction

    // true when a write would alter any writable bit
    function automatic logic alters(input logic [23:0] old_v, input logic [31:0] wd,
                                    input logic [23:0] mask);
        alters = |((old_v ^ wd[23:0]) & mask);
    endfunction

    // the slave stalls while the clock enable is low so no transfer is lost
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign addr_take = hsel && hready && htrans[1] && ce;
    assign rd_take = addr_take && !hwrite;

    // configuration view of both control registers
    always_comb begin
        cfg.clk_external = ctrl_two_reg[`C2_CLK_SOURCE_BIT];
        cfg.pd_reset_select = ctrl_one_reg[`C1_PD_RESET_BIT];
        cfg.single_cycle_mode = ctrl_one_reg[`C1_SINGLE_CYCLE_BIT];
        cfg.continuous_single_cycle = ctrl_one_reg[`C1_CONT_SC_BIT];
        cfg.gain_correction_bypass = ctrl_two_reg[`C2_GAIN_BYPASS_BIT];
        cfg.offset_correction_bypass = ctrl_two_reg[`C2_OFFSET_BYPASS_BIT];
    end

    // data-phase writes detect changes against the stored value
    always_comb begin
        change_one = wr_pend_reg && (wr_idx_reg == `IDX_CTRL_ONE)
            && alters(ctrl_one_reg, hwdata, `C1_WRITE_MASK);
        change_two = wr_pend_reg && (wr_idx_reg == `IDX_CTRL_TWO)
            && alters(ctrl_two_reg, hwdata, `C2_WRITE_MASK);
        conversion_abort = change_one || change_two;
        start = wr_pend_reg && (wr_idx_reg == `IDX_COMMAND) && hwdata[`CMD_START_BIT];
    end

    // register file next values; a new result beats a read clearing ready
    always_comb begin
        ctrl_one_next = ctrl_one_reg;
        ctrl_two_next = ctrl_two_reg;
        gain_next = gain_reg;
        offset_next = offset_reg;
        result_next = result_reg;
        ready_next = ready_reg;
        result_valid_next = take;
        wr_pend_next = addr_take && hwrite;
        wr_idx_next = addr_take ? haddr[11:2] : wr_idx_reg;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                `IDX_CTRL_ONE: ctrl_one_next = merge(ctrl_one_reg, hwdata, `C1_WRITE_MASK);
                `IDX_CTRL_TWO: ctrl_two_next = merge(ctrl_two_reg, hwdata, `C2_WRITE_MASK);
                `IDX_GAIN_COEF: gain_next = hwdata[DATA_W-1:0];
                `IDX_OFFSET_COEF: offset_next = hwdata[DATA_W-1:0];
                default: ;
            endcase
        end
        if (rd_take && haddr[11:2] == `IDX_RESULT) begin
            ready_next = 1'b0;
        end
        if (take) begin
            result_next = corrected;
            ready_next = 1'b1;
        end
    end

    // read mux uses next values of the control and coefficient registers so a read right after a write sees the new data
    always_comb begin
        hrdata_next = hrdata_reg;
        if (rd_take) begin
            case (haddr[11:2])
                `IDX_STATUS: hrdata_next = {28'h0000000, pd_status, running, ready_reg};
                `IDX_CTRL_ONE: hrdata_next = {8'h00, ctrl_one_next};
                `IDX_CTRL_TWO: hrdata_next = {8'h00, ctrl_two_next};
                `IDX_GAIN_COEF: hrdata_next = 32'(gain_next);
                `IDX_OFFSET_COEF: hrdata_next = 32'(offset_next);
                `IDX_RESULT: hrdata_next = 32'(result_reg);
                default: hrdata_next = 32'h00000000;
            endcase
        end
    end

    // register everything; the clock enable freezes all of it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one_reg <= `C1_RESET;
            ctrl_two_reg <= `C2_RESET;
            gain_reg <= DATA_W'(`GAIN_NEUTRAL);
            offset_reg <= DATA_W'(`OFFSET_ZERO);
            result_reg <= '0;
            ready_reg <= 1'b0;
            result_valid_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 10'h000;
            hrdata_reg <= 32'h00000000;
        end else if (ce) begin
            ctrl_one_reg <= ctrl_one_next;
            ctrl_two_reg <= ctrl_two_next;
            gain_reg <= gain_next;
            offset_reg <= offset_next;
            result_reg <= result_next;
            ready_reg <= ready_next;
            result_valid_reg <= result_valid_next;
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // internal oscillator at 0, external clock at 1
    assign clock_source_select = ctrl_two_reg[`C2_CLK_SOURCE_BIT];
    assign modulator_run = running;
    assign result_valid = result_valid_reg;

    conv_sequencer #(
        .FILTER_LATENCY(FILTER_LATENCY)
    ) u_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(start),
        .abort(conversion_abort),
        .cfg(cfg),
        .raw_valid(raw_valid),
        .take(take),
        .running(running),
        .pd_status(pd_status)
    );

    cal_correct #(
        .DATA_W(DATA_W)
    ) u_cal (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg),
        .raw_data(raw_data),
        .gain_coef(gain_reg),
        .offset_coef(offset_reg),
        .corrected(corrected)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_abort_ctrl_two: assert property (ce && wr_pend_reg && wr_idx_reg == 10'h023
        && |((hwdata[23:0] ^ ctrl_two_reg) & 24'hAC0000) && running
        |-> conversion_abort ##1 !running)
        else $error("control two change did not abort");
    a_no_abort_same: assert property (ce && wr_pend_reg
        && (wr_idx_reg == 10'h022 || wr_idx_reg == 10'h023)
        && hwdata[23:0] == (wr_idx_reg == 10'h022 ? ctrl_one_reg : ctrl_two_reg)
        |-> !conversion_abort)
        else $error("unchanged write aborted");
    a_abort_ctrl_one: assert property (ce && wr_pend_reg && wr_idx_reg == 10'h022
        && |((hwdata[23:0] ^ ctrl_one_reg) & 24'h130000) |-> conversion_abort)
        else $error("control one change did not abort");
    a_clk_source: assert property (ce && wr_pend_reg && wr_idx_reg == 10'h023
        |=> clock_source_select == $past(hwdata[23]))
        else $error("clock source not following write");
    a_result_ready: assert property (ce && take |=> ready_reg && result_valid
        && result_reg == $past(corrected))
        else $error("result not captured");
    c_abort: cover property (running && conversion_abort);
    c_continuous_single_cycle: cover property (take ##1 take);
endmodule

// *** hdl/adc_mode_consts.svh ***
// constants for the converter mode control block: offsets, fields, resets, codes
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH

// register indices (byte address is four times the index)
`define IDX_STATUS 10'h020
`define IDX_COMMAND 10'h021
`define IDX_CTRL_ONE 10'h022
`define IDX_CTRL_TWO 10'h023
`define IDX_GAIN_COEF 10'h028
`define IDX_OFFSET_COEF 10'h029
`define IDX_RESULT 10'h02A

// converter_control_one fields
`define C1_PD_RESET_BIT 20
`define C1_SINGLE_CYCLE_BIT 17
`define C1_CONT_SC_BIT 16
`define C1_WRITE_MASK 24'h130000
`define C1_RESET 24'h020000

// converter_control_two fields
`define C2_CLK_SOURCE_BIT 23
`define C2_SYNC_MODE_BIT 21
`define C2_GAIN_BYPASS_BIT 19
`define C2_OFFSET_BYPASS_BIT 18
`define C2_WRITE_MASK 24'hAC0000
`define C2_RESET 24'h000000

// command and status fields
`define CMD_START_BIT 0
`define ST_READY_BIT 0
`define ST_BUSY_BIT 1
`define ST_PD_LSB 2

// power-down status codes
`define PD_CONVERTING 2'h0
`define PD_STANDBY 2'h2
`define PD_IN_RESET 2'h3

// calibration reset values and gain fraction width
`define GAIN_NEUTRAL 24'h400000
`define GAIN_FRAC_BITS 22
`define OFFSET_ZERO 24'h000000

`endif

// *** hdl/adc_mode_pkg.sv ***
// types shared by the converter mode control block
package adc_mode_pkg;

    // configuration bits gathered from both control registers
    typedef struct packed {
        logic clk_external;
        logic pd_reset_select;
        logic single_cycle_mode;
        logic continuous_single_cycle;
        logic gain_correction_bypass;
        logic offset_correction_bypass;
    } mode_cfg_t;

    // one converter sample
    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } sample_t;

    typedef enum logic {
        SEQ_STANDBY,
        SEQ_CONVERT
    } seq_state_t;

endpackage

// *** hdl/conv_sequencer.sv ***
// conversion sequencer: one-shot, continuous single-cycle and filtered modes
`timescale 1ns/100ps
`include "adc_mode_consts.svh"

module conv_sequencer #(
    parameter int FILTER_LATENCY = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic abort,
    input wire adc_mode_pkg::mode_cfg_t cfg,
    input wire logic raw_valid,
    output logic take,
    output logic running,
    output logic [1:0] pd_status
);
    adc_mode_pkg::seq_state_t state_reg, state_next;
    logic [7:0] lat_reg, lat_next;

    // next state; abort beats everything so a config change never yields a stale result
    always_comb begin
        state_next = state_reg;
        lat_next = lat_reg;
        take = 1'b0;
        if (abort) begin
            state_next = adc_mode_pkg::SEQ_STANDBY;
            lat_next = 8'h00;
        end else begin
            case (state_reg)
                adc_mode_pkg::SEQ_STANDBY: begin
                    if (start) begin
                        state_next = adc_mode_pkg::SEQ_CONVERT;
                        lat_next = 8'h00;
                    end
                end
                adc_mode_pkg::SEQ_CONVERT: begin
                    if (raw_valid && cfg.single_cycle_mode) begin
                        take = 1'b1;
                        if (!cfg.continuous_single_cycle) begin
                            state_next = adc_mode_pkg::SEQ_STANDBY;
                        end
                    end else if (raw_valid) begin
                        // filtered mode: the mode bit for repeats is not looked at here
                        if (lat_reg == 8'(FILTER_LATENCY - 1)) begin
                            take = 1'b1;
                        end else begin
                            lat_next = lat_reg + 8'h01;
                        end
                    end
                end
                default: state_next = adc_mode_pkg::SEQ_STANDBY;
            endcase
        end
    end

    // register the sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= adc_mode_pkg::SEQ_STANDBY;
            lat_reg <= 8'h00;
        end else if (ce) begin
            state_reg <= state_next;
            lat_reg <= lat_next;
        end
    end

    assign running = (state_reg == adc_mode_pkg::SEQ_CONVERT);
    // standby shows code 10 unless the power-down selection asks for reset
    assign pd_status = running ? `PD_CONVERTING :
        (cfg.pd_reset_select ? `PD_IN_RESET : `PD_STANDBY);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_oneshot_standby: assert property (ce && running && raw_valid && !abort
        && cfg.single_cycle_mode && !cfg.continuous_single_cycle
        |=> !running && (pd_status != `PD_CONVERTING))
        else $error("one-shot did not return to standby");
    a_continuous_single_cycle_repeats: assert property (ce && running && raw_valid && !abort
        && cfg.single_cycle_mode && cfg.continuous_single_cycle |-> take ##1 running)
        else $error("continuous single-cycle stopped");
    a_filter_ignores: assert property (ce && running && !abort && !cfg.single_cycle_mode
        |=> running)
        else $error("filtered mode left conversion");
    a_filter_latency: assert property (ce && running && raw_valid && !cfg.single_cycle_mode
        && lat_reg < 8'(FILTER_LATENCY - 1) |-> !take)
        else $error("filtered result before latency");
    a_pd_code: assert property (!running && !cfg.pd_reset_select |-> pd_status == 2'h2)
        else $error("standby code wrong");
    c_oneshot: cover property (ce && running && take && !cfg.continuous_single_cycle);
    c_filtered: cover property (ce && take && !cfg.single_cycle_mode);
endmodule

// *** hdl/cal_correct.sv ***
// offset and gain correction of a raw converter sample, with saturation
`timescale 1ns/100ps
`include "adc_mode_consts.svh"

module cal_correct #(
    parameter int DATA_W = 24
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire adc_mode_pkg::mode_cfg_t cfg,
    input wire logic [DATA_W-1:0] raw_data,
    input wire logic [DATA_W-1:0] gain_coef,
    input wire logic [DATA_W-1:0] offset_coef,
    output logic [DATA_W-1:0] corrected
);
    logic [DATA_W-1:0] gain_eff;
    logic [DATA_W-1:0] offset_eff;
    logic signed [DATA_W:0] diff;
    logic signed [2*DATA_W+1:0] prod;
    logic signed [2*DATA_W+1:0] scaled;

    // clamp a wide signed value into the signed output range
    function automatic logic [DATA_W-1:0] sat(input logic signed [2*DATA_W+1:0] v);
        logic signed [2*DATA_W+1:0] hi;
        logic signed [2*DATA_W+1:0] lo;
        hi = (2*DATA_W+2)'((64'sd1 <<< (DATA_W - 1)) - 64'sd1);
        lo = -hi - (2*DATA_W+2)'(1);
        if (v > hi) begin
            sat = hi[DATA_W-1:0];
        end else if (v < lo) begin
            sat = lo[DATA_W-1:0];
        end else begin
            sat = v[DATA_W-1:0];
        end
    endfunction

    // bypass bits force the neutral coefficients, the stored ones stay untouched
    always_comb begin
        gain_eff = cfg.gain_correction_bypass ? DATA_W'(`GAIN_NEUTRAL) : gain_coef;
        offset_eff = cfg.offset_correction_bypass ? DATA_W'(`OFFSET_ZERO) : offset_coef;
        diff = $signed({raw_data[DATA_W-1], raw_data}) - $signed({offset_eff[DATA_W-1], offset_eff});
        prod = (2*DATA_W+2)'(diff) * $signed({2'b00, gain_eff});
        scaled = prod >>> `GAIN_FRAC_BITS;
        corrected = sat(scaled);
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_gain_bypass: assert property (cfg.gain_correction_bypass && cfg.offset_correction_bypass
        |-> corrected == raw_data)
        else $error("bypass did not pass raw data");
    a_offset_bypass: assert property (cfg.offset_correction_bypass |-> offset_eff == 24'h000000)
        else $error("offset bypass not zero");
    a_gain_apply: assert property (!cfg.gain_correction_bypass |-> gain_eff == gain_coef)
        else $error("stored gain not used");
endmodule

// *** test/adc_conversion_mode_control_bench.sv ***
// self-checking bench for the converter mode control block
`timescale 1ns/100ps
`include "adc_mode_consts.svh"

module adc_conversion_mode_control_bench;
    localparam int LAT = 3;
    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic raw_valid;
    logic [23:0] raw_data;
    logic modulator_run;
    logic clock_source_select;
    logic conversion_abort;
    logic result_valid;
    int err_count;
    int checks;
    int abort_cnt;
    int res_cnt;
    int a0;
    int r0;
    logic [31:0] rd;

    adc_mode_ctrl #(.DATA_W(24), .FILTER_LATENCY(LAT)) u_adc_mode_ctrl (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .raw_valid(raw_valid),
        .raw_data(raw_data),
        .modulator_run(modulator_run),
        .clock_source_select(clock_source_select),
        .conversion_abort(conversion_abort),
        .result_valid(result_valid)
    );

    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // pulses counted mid-cycle so the edge ordering never matters
    always @(negedge hclk) begin
        if (conversion_abort === 1'b1) abort_cnt++;
        if (result_valid === 1'b1) res_cnt++;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("ERROR hready expected 1 seen %b", hreadyout);
                close_out();
            end
            @(posedge hclk);
        end
    endtask

    // every bus task is entered and left just after a rising edge
    task automatic bus_xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                            output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {20'h00000, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        bus_xfer(1'b0, idx, 32'h00000000, rd);
        check(what, exp, rd);
    endtask

    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask

    task automatic sample(input logic [23:0] d);
        raw_valid <= 1'b1;
        raw_data <= d;
        @(posedge hclk);
        raw_valid <= 1'b0;
        raw_data <= ~d;
        settle();
    endtask

    task automatic start_conv();
        wr(`IDX_COMMAND, 32'h00000001);
        settle();
        check("run after start", 32'h1, {31'h0, modulator_run});
    endtask

    // one-shot conversion and corrected result readback
    task automatic one_shot(input string what, input logic [23:0] raw, input logic [23:0] exp);
        start_conv();
        sample(raw);
        rd_chk(what, `IDX_RESULT, {8'h00, exp});
    endtask

    task automatic t_reset();
        rd_chk("ctrl one reset", `IDX_CTRL_ONE, 32'h00020000);
        rd_chk("ctrl two reset", `IDX_CTRL_TWO, 32'h00000000);
        check("clock source reset", 32'h0, {31'h0, clock_source_select});
        check("okay response", 32'h0, {31'h0, hresp});
        bus_xfer(1'b0, `IDX_STATUS, 32'h0, rd);
        check("pd status reset", 32'h2, {30'h0, rd[3:2]});
        wr(10'h3FF, 32'h00FFFFFF);
        rd_chk("unmapped", 10'h3FF, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic t_one_shot();
        r0 = res_cnt;
        one_shot("one shot result", 24'h001234, 24'h001234);
        check("one shot count", 32'd1, res_cnt - r0);
        check("one shot standby", 32'h0, {31'h0, modulator_run});
        bus_xfer(1'b0, `IDX_STATUS, 32'h0, rd);
        check("pd status standby", 32'h2, {30'h0, rd[3:2]});
        // power-down selection set to reset changes the standby code
        wr(`IDX_CTRL_ONE, 32'h00120000);
        bus_xfer(1'b0, `IDX_STATUS, 32'h0, rd);
        check("pd status in reset", 32'h3, {30'h0, rd[3:2]});
        wr(`IDX_CTRL_ONE, 32'h00020000);
        sample(24'h000055);
        check("standby ignores sample", 32'd1, res_cnt - r0);
        $display("test one shot done");
    endtask

    task automatic t_cont_sc();
        wr(`IDX_CTRL_ONE, 32'h00030000);
        start_conv();
        r0 = res_cnt;
        sample(24'h000001);
        sample(24'h000002);
        sample(24'h000003);
        check("repeat count", 32'd3, res_cnt - r0);
        // clock enable low: bus stalls and a sample is not taken
        ce <= 1'b0;
        sample(24'h000004);
        check("frozen hready", 32'h0, {31'h0, hreadyout});
        check("frozen sample", 32'd3, res_cnt - r0);
        ce <= 1'b1;
        check("repeat still running", 32'h1, {31'h0, modulator_run});
        a0 = abort_cnt;
        wr(`IDX_CTRL_ONE, 32'h00030000);
        check("same ctrl one no abort", a0, abort_cnt);
        check("same ctrl one running", 32'h1, {31'h0, modulator_run});
        wr(`IDX_CTRL_ONE, 32'h00020000);
        settle();
        check("ctrl one abort", a0 + 1, abort_cnt);
        check("ctrl one aborted", 32'h0, {31'h0, modulator_run});
        $display("test continuous single-cycle done");
    endtask

    task automatic t_filtered();
        // repeat bit at 0: a filtered run must still keep converting
        wr(`IDX_CTRL_ONE, 32'h00000000);
        start_conv();
        r0 = res_cnt;
        repeat (LAT - 1) sample(24'h000010);
        check("filter latency", 32'd0, res_cnt - r0);
        sample(24'h000011);
        sample(24'h000012);
        check("filtered count", 32'd2, res_cnt - r0);
        check("repeat bit ignored", 32'h1, {31'h0, modulator_run});
        a0 = abort_cnt;
        wr(`IDX_CTRL_TWO, 32'h00000000);
        check("same ctrl two no abort", a0, abort_cnt);
        check("same ctrl two running", 32'h1, {31'h0, modulator_run});
        wr(`IDX_CTRL_TWO, 32'h00080000);
        settle();
        check("ctrl two abort", a0 + 1, abort_cnt);
        check("ctrl two aborted", 32'h0, {31'h0, modulator_run});
        $display("test filtered done");
    endtask

    task automatic t_calib();
        wr(`IDX_CTRL_ONE, 32'h00020000);
        wr(`IDX_CTRL_TWO, 32'h00000000);
        wr(`IDX_GAIN_COEF, 32'h00200000);
        rd_chk("gain readback", `IDX_GAIN_COEF, 32'h00200000);
        wr(`IDX_OFFSET_COEF, 32'h00000010);
        // (0x100 - 0x10) * 0.5
        one_shot("gain and offset", 24'h000100, 24'h000078);
        wr(`IDX_CTRL_TWO, 32'h00080000);
        one_shot("gain bypass", 24'h000100, 24'h0000F0);
        wr(`IDX_CTRL_TWO, 32'h000C0000);
        one_shot("both bypass", 24'h000100, 24'h000100);
        wr(`IDX_CTRL_TWO, 32'h00040000);
        one_shot("offset bypass", 24'h000100, 24'h000080);
        $display("test calibration done");
    endtask

    task automatic t_clock();
        wr(`IDX_CTRL_TWO, 32'hFFFFFFFF);
        settle();
        check("external clock", 32'h1, {31'h0, clock_source_select});
        rd_chk("ctrl two writable", `IDX_CTRL_TWO, 32'h00AC0000);
        wr(`IDX_CTRL_TWO, 32'h00000000);
        settle();
        check("internal clock", 32'h0, {31'h0, clock_source_select});
        $display("test clock source done");
    endtask

    initial begin
        err_count = 0;
        checks = 0;
        abort_cnt = 0;
        res_cnt = 0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        raw_valid = 1'b0;
        raw_data = 24'h000000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_one_shot();
        t_cont_sc();
        t_filtered();
        t_calib();
        t_clock();
        close_out();
    end
endmodule
